// ===== lsr_defs.svh
// constants of the link status reporter: codes, map, fields
// assumes inclusion by bare name from the design files
`ifndef LSR_DEFS_SVH
`define LSR_DEFS_SVH

// training-state base codes per group
`define LSR_C_DET       6'h00
`define LSR_C_POL       6'h04
`define LSR_C_CFG       6'h0B
`define LSR_C_CFG_IDLE  6'h15
`define LSR_C_L0        6'h16
`define LSR_C_L1        6'h17
`define LSR_C_L1_EXIT   6'h1B
`define LSR_C_REC       6'h1C
`define LSR_C_REC_IDLE  6'h20
`define LSR_C_HOT_RST   6'h21
`define LSR_C_DIS       6'h22
`define LSR_C_DIS_IDLE  6'h25
`define LSR_C_DP_CFG    6'h26
`define LSR_C_LPBK      6'h2E
`define LSR_C_LPBK_EXIT 6'h30

// register byte offsets
`define LSR_REG_STATE   4'h0
`define LSR_REG_EVENT   4'h4
`define LSR_REG_MASK    4'h8

// state register fields
`define LSR_F_RATE      0
`define LSR_F_WIDTH     1
`define LSR_F_REV       3
`define LSR_F_UPN       5
`define LSR_F_CODE      8

// event bits
`define LSR_EV_UP       0
`define LSR_EV_DOWN     1
`define LSR_EV_RATE     2
`define LSR_EV_WIDTH    3
`define LSR_EV_REV      4
`define LSR_EV_W        5

// reset values
`define LSR_RST_UPN     1'b1
`define LSR_RST_RATE    1'b0
`define LSR_RST_FIELD2  2'h0
`define LSR_RST_EV      5'h00
`define LSR_RST_SUB     3'h0

`endif

// ===== lsr_link_model.sv
// link training side model: drives the link state levels on CLK
// assumes callers reach set_state hierarchically from one sequence
`timescale 1ns/1ps

module lsr_link_model
(
    // clock
    input  wire logic         clk,
    // link state levels
    output lsr_pkg::lsr_group_e group,
    output logic [2:0]        sub,
    output logic              rate,
    output logic [1:0]        width,
    output logic [1:0]        reversal,
    output logic              up
);
    import lsr_pkg::*;

    initial
    begin
        group = LSR_DET;
        sub = 3'h0;
        rate = 1'b0;
        width = 2'h0;
        reversal = 2'h0;
        up = 1'b0;
    end

    // levels change just after a rising edge and then stand
    task set_state(input lsr_group_e g, input logic [2:0] s, input logic r, input logic [1:0] w, input logic [1:0] v,
                   input logic u);
        @(posedge clk);
        group <= g;
        sub <= s;
        rate <= r;
        width <= w;
        reversal <= v;
        up <= u;
    endtask : set_state
endmodule : lsr_link_model

// ===== lsr_pkg.sv
// types shared by the link status reporter
// assumes lsr_defs.svh for numeric constants
package lsr_pkg;

    // training-state group as driven by the state machine
    typedef enum logic [3:0] {
        LSR_DET, LSR_POL, LSR_CFG, LSR_CFG_IDLE, LSR_L0,
        LSR_L1, LSR_L1_EXIT, LSR_REC, LSR_REC_IDLE, LSR_HOT_RST,
        LSR_DIS, LSR_DIS_IDLE, LSR_DP_CFG, LSR_LPBK, LSR_LPBK_EXIT
    } lsr_group_e;

    typedef logic [5:0] lsr_code_t;

endpackage : lsr_pkg

// ===== lsr_top.sv
// link status reporter: registered status outputs, avalon slave, irq
// assumes link inputs come from logic on CLK (the pipe clock)
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "lsr_defs.svh"

module lsr_top
(
    // clock and reset
    input  wire logic               CLK,
    input  wire logic               NRST,
    // link state from the training logic
    input  wire lsr_pkg::lsr_group_e LINK_GROUP,
    input  wire logic [2:0]         LINK_SUB,
    input  wire logic               LINK_RATE,
    input  wire logic [1:0]         LINK_WIDTH,
    input  wire logic [1:0]         LINK_REVERSAL,
    input  wire logic               LINK_UP,
    // status outputs to user logic
    output logic                    CURRENT_RATE_OUT,
    output logic [1:0]              CURRENT_WIDTH_OUT,
    output lsr_pkg::lsr_code_t      TRAINING_STATE_OUT,
    output logic [1:0]              LANE_REVERSAL_OUT,
    output logic                    PHY_LINK_UP_N,
    // avalon-mm slave
    input  wire logic [3:0]         AVS_ADDRESS,
    input  wire logic               AVS_READ,
    input  wire logic               AVS_WRITE,
    input  wire logic [31:0]        AVS_WRITEDATA,
    input  wire logic [3:0]         AVS_BYTEENABLE,
    output logic [31:0]             AVS_READDATA,
    output logic                    AVS_WAITREQUEST,
    // interrupt
    output logic                    IRQ
);
    import lsr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // status outputs

    logic      next_rate;
    logic [1:0] next_width;
    lsr_code_t next_code;
    logic [1:0] next_rev;
    logic      next_upn;

    function automatic lsr_code_t base_of(input lsr_group_e g);
        lsr_code_t b;
        b = `LSR_C_DET;
        case (g)
            LSR_DET:       b = `LSR_C_DET;
            LSR_POL:       b = `LSR_C_POL;
            LSR_CFG:       b = `LSR_C_CFG;
            LSR_CFG_IDLE:  b = `LSR_C_CFG_IDLE;
            LSR_L0:        b = `LSR_C_L0;
            LSR_L1:        b = `LSR_C_L1;
            LSR_L1_EXIT:   b = `LSR_C_L1_EXIT;
            LSR_REC:       b = `LSR_C_REC;
            LSR_REC_IDLE:  b = `LSR_C_REC_IDLE;
            LSR_HOT_RST:   b = `LSR_C_HOT_RST;
            LSR_DIS:       b = `LSR_C_DIS;
            LSR_DIS_IDLE:  b = `LSR_C_DIS_IDLE;
            LSR_DP_CFG:    b = `LSR_C_DP_CFG;
            LSR_LPBK:      b = `LSR_C_LPBK;
            LSR_LPBK_EXIT: b = `LSR_C_LPBK_EXIT;
            default:       b = `LSR_C_DET;
        endcase
        return b;
    endfunction : base_of

    always_comb
    begin
        next_rate  = LINK_RATE;
        next_width = LINK_WIDTH;
        next_rev   = LINK_REVERSAL;
        next_upn   = ~LINK_UP;
        // substate index walks up from the group base
        next_code  = lsr_code_t'(base_of(LINK_GROUP) + {3'h0, LINK_SUB});
    end

    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            CURRENT_RATE_OUT   <= `LSR_RST_RATE;
            CURRENT_WIDTH_OUT  <= `LSR_RST_FIELD2;
            TRAINING_STATE_OUT <= `LSR_C_DET;
            LANE_REVERSAL_OUT  <= `LSR_RST_FIELD2;
            PHY_LINK_UP_N      <= `LSR_RST_UPN;
        end
        else
        begin
            CURRENT_RATE_OUT   <= next_rate;
            CURRENT_WIDTH_OUT  <= next_width;
            TRAINING_STATE_OUT <= next_code;
            LANE_REVERSAL_OUT  <= next_rev;
            PHY_LINK_UP_N      <= next_upn;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // events, mask, irq

    logic [`LSR_EV_W-1:0] event_flags;
    logic [`LSR_EV_W-1:0] mask;
    logic [`LSR_EV_W-1:0] next_event_flags;
    logic [`LSR_EV_W-1:0] next_mask;
    logic [`LSR_EV_W-1:0] ev_set;
    logic [`LSR_EV_W-1:0] ev_clr;
    logic                 acc;
    logic                 next_acc;
    logic [31:0]          next_rdata;

    always_comb
    begin
        ev_set = `LSR_RST_EV;
        ev_set[`LSR_EV_UP]    = LINK_UP & PHY_LINK_UP_N;
        ev_set[`LSR_EV_DOWN]  = ~LINK_UP & ~PHY_LINK_UP_N;
        ev_set[`LSR_EV_RATE]  = LINK_RATE != CURRENT_RATE_OUT;
        ev_set[`LSR_EV_WIDTH] = LINK_WIDTH != CURRENT_WIDTH_OUT;
        ev_set[`LSR_EV_REV]   = LINK_REVERSAL != LANE_REVERSAL_OUT;
        ev_clr = `LSR_RST_EV;
        next_mask = mask;
        if (acc && AVS_WRITE && AVS_BYTEENABLE[0])
        begin
            if (AVS_ADDRESS == `LSR_REG_EVENT)
                ev_clr = AVS_WRITEDATA[`LSR_EV_W-1:0];
            if (AVS_ADDRESS == `LSR_REG_MASK)
                next_mask = AVS_WRITEDATA[`LSR_EV_W-1:0];
        end
        // a new event beats a clear in the same cycle
        next_event_flags = (event_flags & ~ev_clr) | ev_set;
    end

    always_comb
    begin
        IRQ = |(event_flags & mask);
    end

    ////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle per access

    always_comb
    begin
        next_acc   = (AVS_READ | AVS_WRITE) & ~acc;
        next_rdata = AVS_READDATA;
        if (AVS_READ && !acc)
        begin
            next_rdata = 32'h0000_0000;
            case (AVS_ADDRESS)
                `LSR_REG_STATE:
                begin
                    next_rdata[`LSR_F_RATE]            = CURRENT_RATE_OUT;
                    next_rdata[`LSR_F_WIDTH+:2]        = CURRENT_WIDTH_OUT;
                    next_rdata[`LSR_F_REV+:2]          = LANE_REVERSAL_OUT;
                    next_rdata[`LSR_F_UPN]             = PHY_LINK_UP_N;
                    next_rdata[`LSR_F_CODE+:6]         = TRAINING_STATE_OUT;
                end
                `LSR_REG_EVENT: next_rdata[`LSR_EV_W-1:0] = event_flags;
                `LSR_REG_MASK:  next_rdata[`LSR_EV_W-1:0] = mask;
                default:        next_rdata = 32'h0000_0000;
            endcase
        end
        AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~acc;
    end

    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            event_flags  <= `LSR_RST_EV;
            mask         <= `LSR_RST_EV;
            acc          <= 1'b0;
            AVS_READDATA <= 32'h0000_0000;
        end
        else
        begin
            event_flags  <= next_event_flags;
            mask         <= next_mask;
            acc          <= next_acc;
            AVS_READDATA <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    a_rate_follow: assert property ($past(NRST) |-> CURRENT_RATE_OUT == $past(LINK_RATE))
        else $error("rate output does not follow link rate");
    a_width_follow: assert property (##1 CURRENT_WIDTH_OUT == $past(LINK_WIDTH))
        else $error("width output does not follow link width");
    a_det_code: assert property (LINK_GROUP == LSR_DET |=> TRAINING_STATE_OUT == {3'h0, $past(LINK_SUB)})
        else $error("detect substate code wrong");
    a_pol_code: assert property (LINK_GROUP == LSR_POL && LINK_SUB == 3'h0 |=> TRAINING_STATE_OUT == `LSR_C_POL)
        else $error("polling active code wrong");
    a_cfg_idle: assert property (LINK_GROUP == LSR_CFG_IDLE && LINK_SUB == 3'h0 |=> TRAINING_STATE_OUT == 6'h15)
        else $error("config idle code wrong");
    a_l1_exit: assert property (LINK_GROUP == LSR_L1_EXIT && LINK_SUB == 3'h0 |=> TRAINING_STATE_OUT == 6'h1B)
        else $error("L1 exit code wrong");
    a_hot_rst: assert property (LINK_GROUP == LSR_HOT_RST && LINK_SUB == 3'h0 |=> TRAINING_STATE_OUT == 6'h21)
        else $error("hot reset code wrong");
    a_dis_idle: assert property (LINK_GROUP == LSR_DIS_IDLE && LINK_SUB == 3'h0 |=> TRAINING_STATE_OUT == 6'h25)
        else $error("disabled idle code wrong");
    a_dp_cfg: assert property (LINK_GROUP == LSR_DP_CFG && LINK_SUB == 3'h0 |=> TRAINING_STATE_OUT == 6'h26)
        else $error("downstream config code wrong");
    a_lpbk_exit: assert property (LINK_GROUP == LSR_LPBK_EXIT && LINK_SUB == 3'h0 |=> TRAINING_STATE_OUT == 6'h30)
        else $error("loopback exit code wrong");
    a_rev_follow: assert property (##1 LANE_REVERSAL_OUT == $past(LINK_REVERSAL))
        else $error("reversal output does not follow input");
    a_link_low: assert property (LINK_UP |=> !PHY_LINK_UP_N)
        else $error("link up not shown low");
    a_hold_still: assert property ($stable(LINK_RATE) && $stable(LINK_WIDTH) |=> $stable(CURRENT_WIDTH_OUT))
        else $error("width output moved without cause");
    a_up_irq: assert property (LINK_UP && PHY_LINK_UP_N && mask[`LSR_EV_UP] |=> IRQ)
        else $error("link up event raised no irq");
    a_wait_one: assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("waitrequest held over one cycle");

    c_link_up: cover property (PHY_LINK_UP_N ##1 !PHY_LINK_UP_N);
    c_gen2: cover property (!CURRENT_RATE_OUT ##1 CURRENT_RATE_OUT);
    c_irq: cover property (!IRQ ##1 IRQ);
    c_read: cover property (AVS_READ && !AVS_WAITREQUEST);

endmodule : lsr_top

// ===== lsr_top_tb.sv
// self-checking bench of the link status reporter
// assumes lsr_top, lsr_pkg and lsr_link_model are compiled first
`timescale 1ns/1ps

module lsr_top_tb;
    import lsr_pkg::*;

    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        wait_req;
    logic        irq;
    logic        rate_o;
    logic [1:0]  width_o;
    lsr_code_t   code_o;
    logic [1:0]  rev_o;
    logic        upn_o;
    lsr_group_e  l_grp;
    logic [2:0]  l_sub;
    logic        l_rate;
    logic [1:0]  l_width;
    logic [1:0]  l_rev;
    logic        l_up;
    int          n_errors = 0;
    int          num_checks = 0;
    logic [31:0] d;
    lsr_group_e  grp [13] = '{LSR_DET, LSR_POL, LSR_POL, LSR_CFG, LSR_CFG_IDLE, LSR_L1, LSR_L1_EXIT,
                              LSR_REC_IDLE, LSR_HOT_RST, LSR_DIS, LSR_DIS_IDLE, LSR_DP_CFG, LSR_LPBK_EXIT};
    logic [2:0]  sub [13] = '{3'h3, 3'h0, 3'h6, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
    logic [5:0]  cod [13] = '{6'h03, 6'h04, 6'h0A, 6'h0B, 6'h15, 6'h17, 6'h1B, 6'h20, 6'h21, 6'h22, 6'h25, 6'h26, 6'h30};

    initial
    begin
        forever #25 clk = ~clk;
    end

    lsr_link_model lnk_u (.clk(clk), .group(l_grp), .sub(l_sub), .rate(l_rate), .width(l_width),
                          .reversal(l_rev), .up(l_up));

    lsr_top dut_u (.CLK(clk), .NRST(nrst), .LINK_GROUP(l_grp), .LINK_SUB(l_sub), .LINK_RATE(l_rate),
                   .LINK_WIDTH(l_width), .LINK_REVERSAL(l_rev), .LINK_UP(l_up), .CURRENT_RATE_OUT(rate_o),
                   .CURRENT_WIDTH_OUT(width_o), .TRAINING_STATE_OUT(code_o), .LANE_REVERSAL_OUT(rev_o),
                   .PHY_LINK_UP_N(upn_o), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
                   .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
                   .AVS_WAITREQUEST(wait_req), .IRQ(irq));

    ////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    // one access; holds until waitrequest is seen low at an edge
    task access(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
        int n;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= wd;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_req !== 1'b0 && n < 50);
        if (wait_req !== 1'b0)
        begin
            n_errors++;
            $display("unexpected at %0t: waitrequest never dropped", $time);
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : access

    // let the model's change be registered, then sample settled outputs
    task settle;
        @(posedge clk);
        @(negedge clk);
    endtask : settle

    task give_verdict;
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check({rate_o, width_o, code_o, rev_o, upn_o, irq}, 13'h0002);
        access(1'b0, 4'h8, 32'h0, d);
        check(d, 32'h0);
        access(1'b1, 4'h8, 32'h1, d);
        access(1'b0, 4'h8, 32'h0, d);
        check(d, 32'h1);
        check(irq, 1'b0);
        lnk_u.set_state(LSR_DET, 3'h0, 1'b0, 2'h0, 2'h0, 1'b1);
        @(negedge clk);
        check(upn_o, 1'b1);
        settle();
        check(upn_o, 1'b0);
        check(irq, 1'b1);
        access(1'b0, 4'h4, 32'h0, d);
        check(d, 32'h1);
        access(1'b1, 4'h4, 32'h1, d);
        @(negedge clk);
        check(irq, 1'b0);
        access(1'b1, 4'h8, 32'h0, d);
        for (int i = 0; i < 13; i++)
        begin
            lnk_u.set_state(grp[i], sub[i], 1'b0, 2'h0, 2'h0, 1'b1);
            settle();
            check(code_o, cod[i]);
        end
        for (int i = 0; i < 4; i++)
        begin
            lnk_u.set_state(LSR_LPBK_EXIT, 3'h0, i[0], i[1:0], 2'(3 - i), 1'b1);
            settle();
            check({rate_o, width_o, rev_o}, {i[0], i[1:0], 2'(3 - i)});
            check(irq, 1'b0);
        end
        access(1'b0, 4'h0, 32'h0, d);
        check(d, 32'h0000_3007);
        access(1'b0, 4'h4, 32'h0, d);
        check(d, 32'h0000_001C);
        access(1'b1, 4'hC, 32'hFFFF_FFFF, d);
        access(1'b0, 4'hC, 32'h0, d);
        check(d, 32'h0);
        lnk_u.set_state(LSR_DET, 3'h0, 1'b1, 2'h3, 2'h0, 1'b0);
        settle();
        check(upn_o, 1'b1);
        access(1'b0, 4'h4, 32'h0, d);
        check(d, 32'h0000_001E);
        give_verdict();
    end

    initial
    begin
        repeat (2000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
endmodule : lsr_top_tb
